// ===== rtl/sirq_pkg.sv
// constants for the secondary interrupt control block
package sirq_pkg;
  localparam int ADDR_W = 28;
  localparam int DATA_W = 16;
  localparam logic [27:0] DSER_MASK_ADDR = 28'hb000096;
  localparam logic [27:0] LBAT_ROUTE_ADDR = 28'hb000098;
  localparam logic [27:0] SW_REQ_ADDR = 28'hb00009a;
  localparam logic [27:0] SYS2_STATUS_ADDR = 28'hb000200;
  localparam logic [27:0] SYS2_MASK_ADDR = 28'hb000206;
  localparam logic [27:0] EVT_STATUS_ADDR = 28'hb000300;
  localparam logic [27:0] EVT_ENABLE_ADDR = 28'hb000302;
  localparam logic [27:0] EVT_CLEAR_ADDR = 28'hb000304;
  localparam logic [15:0] DSER_MASK_BITS = 16'h0f00;
  localparam logic [15:0] LBAT_ROUTE_BITS = 16'h0001;
  localparam logic [15:0] SW_REQ_BITS = 16'h000f;
  localparam logic [15:0] SYS2_BITS = 16'h003f;
  localparam logic [15:0] EVT_BITS = 16'h003f;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam int DSER_CTS_BIT = 11;
  localparam int DSER_RXERR_BIT = 10;
  localparam int DSER_RXDONE_BIT = 9;
  localparam int DSER_TXDONE_BIT = 8;
  localparam int LBAT_ROUTE_BIT = 0;
  localparam int SYS2_W = 6;
endpackage

// ===== rtl/sirq_sync.sv
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ns
module sirq_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule

// ===== rtl/sirq_top.sv
// secondary interrupt control: masks, low battery routing, soft requests
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module sirq_top
  import sirq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [DATA_W-1:0] rdata,
  input wire logic clear_to_send_change,
  input wire logic serial_receive_error,
  input wire logic serial_receive_done,
  input wire logic serial_transmit_done,
  input wire logic low_battery_detect,
  input wire logic debug_serial_src,
  input wire logic infrared_src,
  input wire logic tick_counter_src,
  input wire logic host_signal_processor_src,
  input wire logic indicator_lamp_src,
  input wire logic long_timer_two_src,
  output logic debug_serial_irq,
  output logic level_zero_interrupt,
  output logic nmi_request,
  output logic [3:0] software_irq,
  output logic [SYS2_W-1:0] system_irq_second,
  output logic irq
);
  logic [DATA_W-1:0] debug_serial_irq_mask_reg;
  logic [DATA_W-1:0] low_battery_irq_routing_reg;
  logic [DATA_W-1:0] software_irq_request_reg;
  logic [DATA_W-1:0] system_irq_mask_second_reg;
  logic [DATA_W-1:0] evt_status_reg;
  logic [DATA_W-1:0] evt_enable_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] system_irq_status_second;
  logic [DATA_W-1:0] evt_set;
  logic [SYS2_W-1:0] sys2_sync;
  logic [4:0] dser_sync;
  logic [SYS2_W-1:0] fwd_prev_reg;
  logic [DATA_W-1:0] sys2_word;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  sirq_sync #(.WIDTH(SYS2_W)) u_sys2_sync (
    .clk(clk),
    .reset(reset),
    .async_in({debug_serial_src, infrared_src, tick_counter_src,
               host_signal_processor_src, indicator_lamp_src,
               long_timer_two_src}),
    .sync_out(sys2_sync)
  );

  sirq_sync #(.WIDTH(5)) u_dser_sync (
    .clk(clk),
    .reset(reset),
    .async_in({clear_to_send_change, serial_receive_error,
               serial_receive_done, serial_transmit_done,
               low_battery_detect}),
    .sync_out(dser_sync)
  );

  // pending flags follow their sources through the two-flop synchroniser
  assign sys2_word = {{(DATA_W-SYS2_W){1'b0}}, sys2_sync};
  assign system_irq_status_second = sys2_word & SYS2_BITS;

  always_ff @(posedge clk) begin
    if (reset) begin
      debug_serial_irq_mask_reg <= RESET_VALUE;
      low_battery_irq_routing_reg <= RESET_VALUE;
      software_irq_request_reg <= RESET_VALUE;
      system_irq_mask_second_reg <= RESET_VALUE;
      evt_enable_reg <= RESET_VALUE;
    end else if (wr_strobe) begin
      if (hit(addr, DSER_MASK_ADDR))
        debug_serial_irq_mask_reg <= wdata & DSER_MASK_BITS;
      if (hit(addr, LBAT_ROUTE_ADDR))
        low_battery_irq_routing_reg <= wdata & LBAT_ROUTE_BITS;
      if (hit(addr, SW_REQ_ADDR))
        software_irq_request_reg <= wdata & SW_REQ_BITS;
      if (hit(addr, SYS2_MASK_ADDR))
        system_irq_mask_second_reg <= wdata & SYS2_BITS;
      if (hit(addr, EVT_ENABLE_ADDR))
        evt_enable_reg <= wdata & EVT_BITS;
    end
  end

  // read data, one cycle after the strobe; status address takes no write
  always_comb begin
    rdata_next = '0;
    if (rd_strobe) begin
      if (hit(addr, DSER_MASK_ADDR))
        rdata_next = debug_serial_irq_mask_reg;
      else if (hit(addr, LBAT_ROUTE_ADDR))
        rdata_next = low_battery_irq_routing_reg;
      else if (hit(addr, SW_REQ_ADDR))
        rdata_next = software_irq_request_reg;
      else if (hit(addr, SYS2_STATUS_ADDR))
        rdata_next = system_irq_status_second;
      else if (hit(addr, SYS2_MASK_ADDR))
        rdata_next = system_irq_mask_second_reg;
      else if (hit(addr, EVT_STATUS_ADDR))
        rdata_next = evt_status_reg;
      else if (hit(addr, EVT_ENABLE_ADDR))
        rdata_next = evt_enable_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      rdata <= '0;
    else
      rdata <= rdata_next;
  end

  // forwarded requests
  always_ff @(posedge clk) begin
    if (reset) begin
      debug_serial_irq <= 1'b0;
      level_zero_interrupt <= 1'b0;
      nmi_request <= 1'b0;
      software_irq <= 4'h0;
      system_irq_second <= '0;
    end else begin
      debug_serial_irq <=
        (dser_sync[4] & debug_serial_irq_mask_reg[DSER_CTS_BIT]) |
        (dser_sync[3] & debug_serial_irq_mask_reg[DSER_RXERR_BIT]) |
        (dser_sync[2] & debug_serial_irq_mask_reg[DSER_RXDONE_BIT]) |
        (dser_sync[1] & debug_serial_irq_mask_reg[DSER_TXDONE_BIT]);
      level_zero_interrupt <= dser_sync[0] &
        low_battery_irq_routing_reg[LBAT_ROUTE_BIT];
      nmi_request <= dser_sync[0] &
        ~low_battery_irq_routing_reg[LBAT_ROUTE_BIT];
      software_irq <= software_irq_request_reg[3:0];
      system_irq_second <= system_irq_status_second[SYS2_W-1:0] &
        system_irq_mask_second_reg[SYS2_W-1:0];
    end
  end

  // sticky events: rising edges of the forwarded system_irq_second requests
  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_prev_reg <= '0;
    end else begin
      fwd_prev_reg <= system_irq_second;
    end
  end

  assign evt_set = {{(DATA_W-SYS2_W){1'b0}},
                    system_irq_second & ~fwd_prev_reg};

  always_ff @(posedge clk) begin
    if (reset)
      evt_status_reg <= RESET_VALUE;
    else if (wr_strobe && hit(addr, EVT_CLEAR_ADDR))
      evt_status_reg <= ((evt_status_reg & ~wdata) | evt_set) & EVT_BITS;
    else
      evt_status_reg <= (evt_status_reg | evt_set) & EVT_BITS;
  end

  assign irq = |(evt_status_reg & evt_enable_reg);

  // a status read returns the synchronised source levels
  sys2_mirror_a: assert property (@(posedge clk) disable iff (reset)
    (rd_strobe && addr == SYS2_STATUS_ADDR) |=>
      rdata == {10'h000, $past(sys2_sync)})
    else $error("status read does not mirror sources");

  fwd_gate_a: assert property (@(posedge clk) disable iff (reset)
    ##1 system_irq_second ==
      $past(sys2_sync & system_irq_mask_second_reg[5:0]))
    else $error("forwarded request not gated by mask");

  route_nmi_a: assert property (@(posedge clk) disable iff (reset)
    (dser_sync[0] && !low_battery_irq_routing_reg[0]) |=> nmi_request)
    else $error("low battery not sent as nmi");

  route_level_zero_interrupt_a: assert property (@(posedge clk) disable iff (reset)
    (dser_sync[0] && low_battery_irq_routing_reg[0]) |=>
      (level_zero_interrupt && !nmi_request))
    else $error("low battery not sent as level zero");

  soft_write_a: assert property (@(posedge clk) disable iff (reset)
    (wr_strobe && addr == SW_REQ_ADDR) |=> ##1 software_irq == $past(wdata[3:0], 2))
    else $error("software request not taken");

  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    (debug_serial_irq_mask_reg & ~DSER_MASK_BITS) == 16'h0000 &&
    (low_battery_irq_routing_reg & ~LBAT_ROUTE_BITS) == 16'h0000)
    else $error("reserved bit set");

  cts_mask_a: assert property (@(posedge clk) disable iff (reset)
    (dser_sync[4] && debug_serial_irq_mask_reg[11]) |=> debug_serial_irq)
    else $error("cts change not forwarded");

  dser_block_a: assert property (@(posedge clk) disable iff (reset)
    (debug_serial_irq_mask_reg[11:8] == 4'h0) |=> !debug_serial_irq)
    else $error("masked serial interrupt forwarded");

  sys2_mask_a: assert property (@(posedge clk) disable iff (reset)
    (system_irq_mask_second_reg == 16'h0000) |=> system_irq_second == '0)
    else $error("masked system source forwarded");

  rxerr_mask_a: assert property (@(posedge clk) disable iff (reset)
    (dser_sync[3] && debug_serial_irq_mask_reg[10]) |=> debug_serial_irq)
    else $error("receive error not forwarded");

  rxdone_mask_a: assert property (@(posedge clk) disable iff (reset)
    (dser_sync[2] && debug_serial_irq_mask_reg[9]) |=> debug_serial_irq)
    else $error("receive done not forwarded");

  txdone_mask_a: assert property (@(posedge clk) disable iff (reset)
    (dser_sync[1] && debug_serial_irq_mask_reg[8]) |=> debug_serial_irq)
    else $error("transmit done not forwarded");

  dser_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !((dser_sync[4] && debug_serial_irq_mask_reg[11]) ||
      (dser_sync[3] && debug_serial_irq_mask_reg[10]) ||
      (dser_sync[2] && debug_serial_irq_mask_reg[9]) ||
      (dser_sync[1] && debug_serial_irq_mask_reg[8])) |=> !debug_serial_irq)
    else $error("serial interrupt without enabled source");

  dser_take_a: assert property (@(posedge clk) disable iff (reset)
    (wr_strobe && addr == DSER_MASK_ADDR) |=>
      debug_serial_irq_mask_reg[11:8] == $past(wdata[11:8]))
    else $error("serial mask write not taken");

  route_take_a: assert property (@(posedge clk) disable iff (reset)
    (wr_strobe && addr == LBAT_ROUTE_ADDR) |=>
      low_battery_irq_routing_reg[0] == $past(wdata[0]))
    else $error("routing write not taken");

  lbat_idle_a: assert property (@(posedge clk) disable iff (reset)
    !dser_sync[0] |=> (!nmi_request && !level_zero_interrupt))
    else $error("low battery request without detection");

  route_excl_a: assert property (@(posedge clk) disable iff (reset)
    !(nmi_request && level_zero_interrupt))
    else $error("low battery sent both ways");

  soft_hold_a: assert property (@(posedge clk) disable iff (reset)
    !(wr_strobe && addr == SW_REQ_ADDR) |=> ##1 $stable(software_irq))
    else $error("software request changed without write");

  // pending bits follow their pins two edges late, once out of reset
  dser_pend_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset, 2) |->
      system_irq_status_second[5] == $past(debug_serial_src, 2))
    else $error("debug serial pending bit wrong");

  ir_pend_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset, 2) |->
      system_irq_status_second[4] == $past(infrared_src, 2))
    else $error("infrared pending bit wrong");

  tick_pend_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset, 2) |->
      system_irq_status_second[3] == $past(tick_counter_src, 2))
    else $error("tick counter pending bit wrong");

  hsp_pend_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset, 2) |->
      system_irq_status_second[2] == $past(host_signal_processor_src, 2))
    else $error("signal processor pending bit wrong");

  lamp_pend_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset, 2) |->
      system_irq_status_second[1] == $past(indicator_lamp_src, 2))
    else $error("indicator lamp pending bit wrong");

  timer_pend_a: assert property (@(posedge clk) disable iff (reset)
    !$past(reset, 2) |->
      system_irq_status_second[0] == $past(long_timer_two_src, 2))
    else $error("long timer two pending bit wrong");

  dser_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    (rd_strobe && addr == DSER_MASK_ADDR) |=>
      (rdata & ~DSER_MASK_BITS) == 16'h0000)
    else $error("serial mask reserved bit read as one");

  lbat_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    (rd_strobe && addr == LBAT_ROUTE_ADDR) |=>
      (rdata & ~LBAT_ROUTE_BITS) == 16'h0000)
    else $error("routing reserved bit read as one");

  soft_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    (rd_strobe && addr == SW_REQ_ADDR) |=>
      (rdata & ~SW_REQ_BITS) == 16'h0000)
    else $error("software request reserved bit read as one");

  mask2_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    (rd_strobe && addr == SYS2_MASK_ADDR) |=>
      (rdata & ~SYS2_BITS) == 16'h0000)
    else $error("system mask reserved bit read as one");

  unmapped_rd_a: assert property (@(posedge clk) disable iff (reset)
    (rd_strobe && addr[27:4] == 24'hb0000a) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  mask_take_a: assert property (@(posedge clk) disable iff (reset)
    (wr_strobe && addr == SYS2_MASK_ADDR) |=>
      system_irq_mask_second_reg == ($past(wdata) & SYS2_BITS))
    else $error("system mask write not taken");

  status_wr_a: assert property (@(posedge clk) disable iff (reset)
    (wr_strobe && addr == SYS2_STATUS_ADDR) |=>
      ($stable(debug_serial_irq_mask_reg) &&
       $stable(low_battery_irq_routing_reg) &&
       $stable(software_irq_request_reg) &&
       $stable(system_irq_mask_second_reg)))
    else $error("status write disturbed a register");

  evt_sticky_a: assert property (@(posedge clk) disable iff (reset)
    (evt_set != 16'h0000) |=>
      (evt_status_reg & $past(evt_set)) == $past(evt_set))
    else $error("forwarded edge not latched");

  evt_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wr_strobe && addr == EVT_CLEAR_ADDR && evt_set == 16'h0000) |=>
      (evt_status_reg & $past(wdata)) == 16'h0000)
    else $error("event clear not taken");

  reset_out_a: assert property (@(posedge clk)
    reset |=> (rdata == 16'h0000 && software_irq == 4'h0 &&
      system_irq_second == '0 && !debug_serial_irq &&
      !level_zero_interrupt && !nmi_request && !irq))
    else $error("request forwarded out of reset");
endmodule

// ===== verif/sirq_src_model.sv
// behavioural model of the peripheral interrupt sources
`timescale 1ns/1ns
module sirq_src_model (
  input wire logic clk,
  input wire logic [10:0] want,
  output logic [10:0] src
);
  initial src = 11'h000;
  // levels move just after an edge, unrelated to any register access
  always @(posedge clk) src <= want;
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the secondary interrupt control block
`timescale 1ns/1ns
module tb_top;
  import sirq_pkg::*;
  logic clk = 1'h0, reset = 1'h1, wr_strobe = 1'h0, rd_strobe = 1'h0;
  logic rd_pend = 1'h0;
  logic [ADDR_W-1:0] addr = 28'h0000000;
  logic [DATA_W-1:0] wdata = 16'h0000, rdata, p, m;
  logic [10:0] want = 11'h000, src;
  logic [3:0] software_irq;
  logic [SYS2_W-1:0] system_irq_second;
  logic debug_serial_irq, level_zero_interrupt, nmi_request, irq;
  logic [DATA_W-1:0] notes[$];
  logic [27:0] regs[5] = '{DSER_MASK_ADDR, LBAT_ROUTE_ADDR, SW_REQ_ADDR,
    SYS2_STATUS_ADDR, SYS2_MASK_ADDR};
  logic [15:0] bits[5] = '{DSER_MASK_BITS, LBAT_ROUTE_BITS, SW_REQ_BITS,
    16'h0000, SYS2_BITS};
  int n_mismatch = 0, n_checks = 0, i;
  always #50 clk = ~clk;
  sirq_src_model sirq_src_model_i (.clk(clk), .want(want), .src(src));
  sirq_top sirq_top_i (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rdata(rdata), .clear_to_send_change(src[9]),
    .serial_receive_error(src[8]), .serial_receive_done(src[7]),
    .serial_transmit_done(src[6]), .low_battery_detect(src[10]),
    .debug_serial_src(src[5]), .infrared_src(src[4]),
    .tick_counter_src(src[3]), .host_signal_processor_src(src[2]),
    .indicator_lamp_src(src[1]), .long_timer_two_src(src[0]),
    .debug_serial_irq(debug_serial_irq),
    .level_zero_interrupt(level_zero_interrupt),
    .nmi_request(nmi_request), .software_irq(software_irq),
    .system_irq_second(system_irq_second), .irq(irq));
  task test_done;
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [27:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'h1;
    @(posedge clk);
    wr_strobe <= 1'h0;
  endtask
  task rd(input logic [27:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'h1;
    notes.push_back(e);
    @(posedge clk);
    rd_strobe <= 1'h0;
  endtask
  // sources pass two sync flops and an output register
  task settle;
    repeat (6) @(posedge clk);
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_pend) chk("rdata", rdata, notes.pop_front());
    rd_pend <= rd_strobe;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
  initial begin
    i = $urandom(43);
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    for (i = 0; i < 5; i++) rd(regs[i], 16'h0000);
    rd(28'hb0000a0, 16'h0000);
    for (i = 0; i < 5; i++) begin
      wr(regs[i], 16'hffff);
      rd(regs[i], bits[i]);
    end
    for (i = 0; i < 3; i++) begin
      p = 16'($urandom()) & 16'h000f;
      wr(SW_REQ_ADDR, p);
      settle;
      chk("software_irq", {12'h000, software_irq}, p);
    end
    for (i = 0; i < 4; i++) begin
      wr(DSER_MASK_ADDR, 16'h0100 << i);
      want <= 11'h3c0 ^ (11'h040 << i);
      settle;
      chk("debug_serial_irq", {15'h0000, debug_serial_irq}, 16'h0000);
      want <= 11'h040 << i;
      settle;
      chk("debug_serial_irq", {15'h0000, debug_serial_irq}, 16'h0001);
    end
    for (i = 0; i < 2; i++) begin
      wr(LBAT_ROUTE_ADDR, i[15:0]);
      want <= 11'h400;
      settle;
      chk("route", {14'h0000, level_zero_interrupt, nmi_request},
        i ? 16'h0002 : 16'h0001);
    end
    for (i = 0; i < 4; i++) begin
      p = 16'($urandom()) & 16'h003f;
      m = 16'($urandom()) & 16'h003f;
      wr(SYS2_MASK_ADDR, m);
      want <= p[10:0];
      settle;
      rd(SYS2_STATUS_ADDR, p);
      chk("system_irq_second", {10'h000, system_irq_second}, p & m);
    end
    wr(SYS2_MASK_ADDR, 16'h003f);
    want <= 11'h000;
    settle;
    wr(EVT_CLEAR_ADDR, 16'h003f);
    wr(EVT_ENABLE_ADDR, 16'h0001);
    want <= 11'h020;
    settle;
    chk("irq", {15'h0000, irq}, 16'h0000);
    want <= 11'h021;
    settle;
    want <= 11'h000;
    settle;
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd(EVT_STATUS_ADDR, 16'h0021);
    wr(EVT_CLEAR_ADDR, 16'h0001);
    settle;
    chk("irq", {15'h0000, irq}, 16'h0000);
    rd(EVT_STATUS_ADDR, 16'h0020);
    // a second reset in mid-run must bring the software request, serial mask and event status registers back to zero
    @(posedge clk);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    rd(SW_REQ_ADDR, 16'h0000);
    rd(DSER_MASK_ADDR, 16'h0000);
    rd(EVT_STATUS_ADDR, 16'h0000);
    chk("software_irq", {12'h000, software_irq}, 16'h0000);
    chk("irq", {15'h0000, irq}, 16'h0000);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule
